// ---- src/ddrbc_consts.vh ----
// Constants for the DDR burst access core
`ifndef DDRBC_CONSTS_VH
`define DDRBC_CONSTS_VH
`define DDRBC_DQ_W        8
`define DDRBC_ROW_W       15
`define DDRBC_COL_W       10
`define DDRBC_BANK_W      3
`define DDRBC_BANKS       8
`define DDRBC_MEM_AW      6
`define DDRBC_BEATS_BL8   4'h8
`define DDRBC_BEATS_BC4   4'h4
`define DDRBC_CMD_NOP     3'h7
`define DDRBC_CMD_ACT     3'h3
`define DDRBC_CMD_RD      3'h5
`define DDRBC_CMD_WR      3'h4
`define DDRBC_CMD_PRE     3'h2
`define DDRBC_CMD_REF     3'h1
`define DDRBC_CMD_MRS     3'h0
`define DDRBC_AP_BIT      10
`define DDRBC_BC_BIT      12
`define DDRBC_RD_LAT      4'h5
`define DDRBC_WR_LAT      4'h4
`define DDRBC_AP_DELAY    4'h3
`define DDRBC_PRE_LEN     2'h2
`endif

// ---- src/ddrbc_mem.v ----
// Small word-wide storage with registered read data
`timescale 1ns/1ps
module ddrbc_mem
(
   clock,
   wr_en,
   wr_addr,
   wr_data,
   rd_addr,
   rd_data
);
`include "ddrbc_consts.vh"
   input  wire                          clock;
   input  wire                          wr_en;
   input  wire [`DDRBC_MEM_AW-1:0]      wr_addr;
   input  wire [`DDRBC_DQ_W-1:0]        wr_data;
   input  wire [`DDRBC_MEM_AW-1:0]      rd_addr;
   output reg  [`DDRBC_DQ_W-1:0]        rd_data;

   reg [`DDRBC_DQ_W-1:0] store [0:(1<<`DDRBC_MEM_AW)-1];

   always @(posedge clock)
   begin
      if (wr_en)
      begin
         store[wr_addr] <= wr_data;
      end
      rd_data <= store[rd_addr];
   end
endmodule // ddrbc_mem

// ---- src/ddrbc_core.v ----
// Eight-bank DDR burst access core, oversampling the memory clock
`timescale 1ns/1ps
module ddrbc_core
(
   clock,
   reset_n,
   mem_clock,
   clock_enable,
   chip_select_n,
   row_strobe_n,
   col_strobe_n,
   write_enable_n,
   bank_addr,
   addr,
   dq_in,
   dq_out,
   dq_oe,
   dqs_in,
   dqs_out,
   dqs_oe,
   chop_default,
   dll_enable,
   bank_open,
   self_refresh,
   power_down,
   illegal_access
);
`include "ddrbc_consts.vh"
   input  wire                          clock;
   input  wire                          reset_n;
   input  wire                          mem_clock;
   input  wire                          clock_enable;
   input  wire                          chip_select_n;
   input  wire                          row_strobe_n;
   input  wire                          col_strobe_n;
   input  wire                          write_enable_n;
   input  wire [`DDRBC_BANK_W-1:0]      bank_addr;
   input  wire [`DDRBC_ROW_W-1:0]       addr;
   input  wire [`DDRBC_DQ_W-1:0]        dq_in;
   output reg  [`DDRBC_DQ_W-1:0]        dq_out;
   output reg                           dq_oe;
   input  wire                          dqs_in;
   output reg                           dqs_out;
   output reg                           dqs_oe;
   input  wire                          chop_default;
   input  wire                          dll_enable;
   output reg  [`DDRBC_BANKS-1:0]       bank_open;
   output reg                           self_refresh;
   output reg                           power_down;
   output reg                           illegal_access;

   localparam ST_IDLE  = 3'h0;
   localparam ST_WLAT  = 3'h1;
   localparam ST_WDATA = 3'h2;
   localparam ST_RLAT  = 3'h3;
   localparam ST_RPRE  = 3'h4;
   localparam ST_RDATA = 3'h5;

   // Two-flop synchronisers for every pin input except reset_n and chop_default
   reg [2:0]                    ck_sync;
   reg [1:0]                    dqs_sync0;
   reg                          dqs_prev;
   reg [5:0]                    ctl_s0;
   reg [5:0]                    ctl_s1;
   reg [`DDRBC_BANK_W-1:0]      ba_s0;
   reg [`DDRBC_BANK_W-1:0]      ba_s1;
   reg [`DDRBC_ROW_W-1:0]       a_s0;
   reg [`DDRBC_ROW_W-1:0]       a_s1;
   reg [`DDRBC_DQ_W-1:0]        dq_s0;
   reg [`DDRBC_DQ_W-1:0]        dq_s1;

   always @(posedge clock)
   begin
      ck_sync   <= {ck_sync[1:0], mem_clock};
      dqs_sync0 <= {dqs_sync0[0], dqs_in};
      dqs_prev  <= dqs_sync0[1];
      ctl_s0    <= {clock_enable, dll_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n};
      ctl_s1    <= ctl_s0;
      ba_s0     <= bank_addr;
      ba_s1     <= ba_s0;
      a_s0      <= addr;
      a_s1      <= a_s0;
      dq_s0     <= dq_in;
      dq_s1     <= dq_s0;
   end

   // Rising and falling memory clock edges; pins lag two cycles, so commands line up
   wire ck_rise = ck_sync[1] & ~ck_sync[2];
   wire ck_fall = ~ck_sync[1] & ck_sync[2];
   wire ck_edge = ck_rise | ck_fall;
   wire dqs_rise = dqs_sync0[1] & ~dqs_prev;
   wire dqs_edge = dqs_sync0[1] ^ dqs_prev;
   wire cke_s = ctl_s1[5];
   wire dll_s = ctl_s1[4];
   wire [2:0] cmd = ctl_s1[3] ? `DDRBC_CMD_NOP : ctl_s1[2:0];
   wire cmd_valid = ck_rise & cke_s & dll_s;
   // Per-bank open row and pending auto close
   reg [`DDRBC_ROW_W-1:0]       open_row [0:`DDRBC_BANKS-1];
   reg [3:0]                    ap_count [0:`DDRBC_BANKS-1];
   reg [2:0]                    state;
   reg [3:0]                    lat_count;
   reg [3:0]                    beats;
   reg [3:0]                    beat_idx;
   reg [`DDRBC_BANK_W-1:0]      cur_bank;
   reg [`DDRBC_COL_W-1:0]       start_col;
   reg                          cur_ap;
   reg                          dqs_started;
   reg [1:0]                    pre_count;
   wire is_rd = cmd_valid & (cmd == `DDRBC_CMD_RD);
   wire is_wr = cmd_valid & (cmd == `DDRBC_CMD_WR);
   wire is_act = cmd_valid & (cmd == `DDRBC_CMD_ACT);
   wire is_pre = cmd_valid & (cmd == `DDRBC_CMD_PRE);
   wire is_ref = cmd_valid & (cmd == `DDRBC_CMD_REF);
   // Chop bit low, or the programmed chop setting, gives four beats
   wire [3:0] req_beats = (~a_s1[`DDRBC_BC_BIT] | chop_default) ? `DDRBC_BEATS_BC4 : `DDRBC_BEATS_BL8;
   // Sequential wrap inside the 8-beat block (chop wraps in 4) from the start column
   wire [2:0] beat_ofs = (beats == `DDRBC_BEATS_BC4) ? {start_col[2], start_col[1:0] + beat_idx[1:0]} :
                         start_col[2:0] + beat_idx[2:0];
   wire [`DDRBC_ROW_W-1:0] row_now = open_row[cur_bank];
   // Storage indexed by bank and low column bits; row left out to fit a small array
   wire [`DDRBC_MEM_AW-1:0] mem_addr = {cur_bank, beat_ofs};
   wire mem_wr = (state == ST_WDATA) & dqs_edge & (dqs_started | dqs_rise);
   wire [`DDRBC_DQ_W-1:0] mem_rdata;
   ddrbc_mem u_mem
   (
      .clock   (clock),
      .wr_en   (mem_wr),
      .wr_addr (mem_addr),
      .wr_data (dq_s1),
      .rd_addr (mem_addr),
      .rd_data (mem_rdata)
   );
   genvar gi;
   generate
      for (gi = 0; gi < `DDRBC_BANKS; gi = gi + 1)
      begin : g_bank
         localparam [`DDRBC_BANK_W-1:0] BANK_ID = gi;
         wire hit = (ba_s1 == BANK_ID);
         always @(posedge clock)
         begin
            if (!reset_n)
            begin
               bank_open[gi] <= 1'b0;
               open_row[gi]  <= {`DDRBC_ROW_W{1'b0}};
               ap_count[gi]  <= 4'h0;
            end
            else if (is_act & hit)
            begin
               bank_open[gi] <= 1'b1;
               open_row[gi]  <= a_s1;
            end
            else if ((is_pre & (hit | a_s1[`DDRBC_AP_BIT])) | ((ap_count[gi] == 4'h1) & ck_rise))
            begin
               bank_open[gi] <= 1'b0;
               ap_count[gi]  <= 4'h0;
            end
            else if ((state == ST_WDATA | state == ST_RDATA) & cur_ap & (cur_bank == BANK_ID) &
                     (beat_idx == beats - 4'h1) & ck_edge)
            begin
               ap_count[gi] <= `DDRBC_AP_DELAY;
            end
            else if ((ap_count[gi] != 4'h0) & ck_rise)
            begin
               ap_count[gi] <= ap_count[gi] - 4'h1;
            end
         end
      end
   endgenerate

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         state          <= ST_IDLE;
         lat_count      <= 4'h0;
         beats          <= `DDRBC_BEATS_BL8;
         beat_idx       <= 4'h0;
         cur_bank       <= {`DDRBC_BANK_W{1'b0}};
         start_col      <= {`DDRBC_COL_W{1'b0}};
         cur_ap         <= 1'b0;
         dqs_started    <= 1'b0;
         pre_count      <= 2'h0;
         dq_out         <= {`DDRBC_DQ_W{1'b0}};
         dq_oe          <= 1'b0;
         dqs_out        <= 1'b0;
         dqs_oe         <= 1'b0;
         illegal_access <= 1'b0;
      end
      else
      begin
         case (state)
            ST_IDLE:
            begin
               dq_oe  <= 1'b0;
               dqs_oe <= 1'b0;
               if (is_rd | is_wr)
               begin
                  cur_bank  <= ba_s1;
                  start_col <= a_s1[`DDRBC_COL_W-1:0];
                  cur_ap    <= a_s1[`DDRBC_AP_BIT];
                  beats     <= req_beats;
                  beat_idx  <= 4'h0;
                  lat_count <= is_rd ? `DDRBC_RD_LAT : `DDRBC_WR_LAT;
                  illegal_access <= ~bank_open[ba_s1];
                  dqs_started <= 1'b0;
                  state <= is_rd ? ST_RLAT : ST_WLAT;
               end
            end
            ST_WLAT:
            begin
               if (ck_rise)
               begin
                  lat_count <= lat_count - 4'h1;
                  if (lat_count == 4'h1)
                  begin
                     state <= ST_WDATA;
                  end
               end
            end
            ST_WDATA:
            begin
               // Preamble ignored: the first rising strobe edge opens capture
               if (dqs_rise)
               begin
                  dqs_started <= 1'b1;
               end
               if (mem_wr)
               begin
                  beat_idx <= beat_idx + 4'h1;
                  if (beat_idx == beats - 4'h1)
                  begin
                     state <= ST_IDLE;
                  end
               end
            end
            ST_RLAT:
            begin
               if (ck_rise)
               begin
                  lat_count <= lat_count - 4'h1;
                  if (lat_count == 4'h1)
                  begin
                     state     <= ST_RPRE;
                     pre_count <= `DDRBC_PRE_LEN;
                     dqs_oe    <= 1'b1;
                     dqs_out   <= 1'b0;
                  end
               end
            end
            ST_RPRE:
            begin
               // Strobe held low for the preamble half-clocks
               if (ck_edge)
               begin
                  pre_count <= pre_count - 2'h1;
                  if (pre_count == 2'h1)
                  begin
                     state    <= ST_RDATA;
                     dq_oe    <= 1'b1;
                     dq_out   <= mem_rdata;
                     dqs_out  <= 1'b1;
                     beat_idx <= 4'h1;
                  end
               end
            end
            ST_RDATA:
            begin
               if (ck_edge)
               begin
                  if (beat_idx == beats)
                  begin
                     state   <= ST_IDLE;
                     dq_oe   <= 1'b0;
                     dqs_out <= 1'b0;
                  end
                  else
                  begin
                     dq_out   <= mem_rdata;
                     dqs_out  <= ~dqs_out;
                     beat_idx <= beat_idx + 4'h1;
                  end
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Low-power states follow clock_enable falling with or without a refresh command
   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         self_refresh <= 1'b0;
         power_down   <= 1'b0;
      end
      else if (ck_rise)
      begin
         if (!cke_s & !self_refresh & !power_down)
         begin
            self_refresh <= is_ref | (ctl_s1[3:0] == {1'b0, `DDRBC_CMD_REF});
            power_down   <= ~(ctl_s1[3:0] == {1'b0, `DDRBC_CMD_REF});
         end
         else if (cke_s)
         begin
            self_refresh <= 1'b0;
            power_down   <= 1'b0;
         end
      end
   end
endmodule // ddrbc_core

// ---- sim/ddrbc_core_props.sv ----
// Assertion checker for the DDR burst access core
`timescale 1ns/1ps
module ddrbc_core_props
(
   input wire       clock,
   input wire       reset_n,
   input wire       dll_enable,
   input wire [2:0] bank_addr,
   input wire [7:0] dq_out,
   input wire       dq_oe,
   input wire       dqs_out,
   input wire       dqs_oe,
   input wire [7:0] bank_open,
   input wire       self_refresh,
   input wire       illegal_access
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   reg       prev_dqs;
   reg [3:0] edges;
   // Strobe edges seen while read data is driven
   always @(posedge clock)
   begin
      prev_dqs <= dqs_out;
      edges    <= dq_oe ? edges + {3'h0, dqs_out ^ prev_dqs} : 4'h0;
   end
   reset_clear_a:
      assert property ($rose(reset_n) |-> bank_open == 8'h00 && !dq_oe && !dqs_oe) else $error("outputs not clear");
   dll_hold_a:
      assert property (!dll_enable [*8] |=> (bank_open & ~$past(bank_open)) == 8'h00) else $error("bank opened");
   strobe_with_a:
      assert property (dq_oe |-> dqs_oe) else $error("data without strobe");
   first_beat_a:
      assert property ($rose(dq_oe) |-> dqs_out && !$past(dqs_out) && $past(dqs_oe, 8)) else $error("bad preamble");
   edge_align_a:
      assert property (dq_oe && $past(dq_oe) && $changed(dq_out) |-> $changed(dqs_out)) else $error("data off edge");
   burst_beats_a:
      assert property ($fell(dq_oe) |-> edges inside {4'h4, 4'h8}) else $error("bad beat count");
   quiet_refresh_a:
      assert property (self_refresh |-> !dq_oe && !dqs_oe) else $error("drive in self refresh");
   closed_bank_a:
      assert property ($rose(illegal_access) |-> (($past(bank_open) >> $past(bank_addr, 3)) & 8'h01) == 8'h00)
         else $error("false access flag");
endmodule // ddrbc_core_props
bind ddrbc_core ddrbc_core_props u_props
(
   .clock(clock), .reset_n(reset_n), .dll_enable(dll_enable), .bank_addr(bank_addr), .dq_out(dq_out), .dq_oe(dq_oe),
   .dqs_out(dqs_out), .dqs_oe(dqs_oe), .bank_open(bank_open), .self_refresh(self_refresh),
   .illegal_access(illegal_access)
);

// ---- sim/ddrbc_host.sv ----
// Behavioural memory controller facing the core
`timescale 1ns/1ps
`include "ddrbc_consts.vh"
module ddrbc_host
(
   output logic        mem_clock,
   output logic        clock_enable,
   output logic        chip_select_n,
   output logic        row_strobe_n,
   output logic        col_strobe_n,
   output logic        write_enable_n,
   output logic [2:0]  bank_addr,
   output logic [14:0] addr,
   output logic [7:0]  host_dq,
   output logic        host_dqs,
   input  wire  [7:0]  dq_out,
   input  wire         dq_oe,
   input  wire         dqs_out
);
   logic [7:0] rd_q [0:7];
   initial
   begin
      {clock_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 5'h1f;
      {mem_clock, host_dqs, bank_addr, addr, host_dq} = 28'h000_0000;
      #3.3;
      forever
         #24 mem_clock = ~mem_clock;
   end
   // Held across one rising edge; released bus shows inverse
   task automatic issue(input logic [2:0] code, input logic [2:0] bank, input logic [14:0] a, input logic cke);
   begin
      @(negedge mem_clock);
      {row_strobe_n, col_strobe_n, write_enable_n} = code;
      {chip_select_n, clock_enable, bank_addr, addr} = {1'b0, cke, bank, a};
      @(negedge mem_clock);
      {chip_select_n, row_strobe_n, col_strobe_n, write_enable_n} = 4'hf;
      {bank_addr, addr} = ~{bank, a};
   end
   endtask
   // Refresh commands per nominal interval, scaled with case temperature
   function automatic int refresh_scale(input logic ultra, input int temp_c);
      return (temp_c <= 85) ? 1 : (!ultra || temp_c <= 105) ? 2 : (temp_c <= 115) ? 4 : 8;
   endfunction
   // Strobe a quarter period after data, centred
   task automatic write_beats(input logic [7:0] d [0:7], input int n);
   begin
      repeat (4) @(posedge mem_clock);
      for (int i = 0; i < n; i++)
      begin
         host_dq = d[i];
         #12 host_dqs = ~host_dqs;
         #12;
      end
      host_dq = ~d[n-1];
   end
   endtask
   // Sampled mid-beat, since read data is edge aligned
   task automatic read_beats(input int n);
      int k;
   begin
      k = 0;
      foreach (rd_q[i])
         rd_q[i] = 8'hxx;
      while (dq_oe !== 1'b1 && k < 900)
      begin
         #1;
         k++;
      end
      for (int i = 0; i < n && k < 900; i++)
      begin
         #10 rd_q[i] = dq_out;
         if (i < n - 1)
            @(dqs_out);
      end
   end
   endtask
endmodule // ddrbc_host

// ---- sim/ddrbc_core_tb.sv ----
// Self-checking bench for the DDR burst access core
`timescale 1ns/1ps
`include "ddrbc_consts.vh"
module ddrbc_core_tb;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        dll_enable = 1'b1;
   logic        chop_default = 1'b0;
   wire         mem_clock, clock_enable, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n;
   wire  [2:0]  bank_addr;
   wire  [14:0] addr;
   wire  [7:0]  dq_out, dq_in, host_dq, bank_open;
   wire         dq_oe, dqs_out, dqs_oe, dqs_in, host_dqs, self_refresh, power_down, illegal_access;
   int          fails = 0;
   int          n_checks = 0;
   int          cycles = 0;
   logic [7:0]  wdat [0:7];
   assign dq_in  = dq_oe ? dq_out : host_dq;
   assign dqs_in = dqs_oe ? dqs_out : host_dqs;
   ddrbc_host host
   (
      .mem_clock(mem_clock), .clock_enable(clock_enable), .chip_select_n(chip_select_n),
      .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n),
      .bank_addr(bank_addr), .addr(addr), .host_dq(host_dq), .host_dqs(host_dqs),
      .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out)
   );
   ddrbc_core uut
   (
      .clock(clock), .reset_n(reset_n), .mem_clock(mem_clock), .clock_enable(clock_enable),
      .chip_select_n(chip_select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
      .write_enable_n(write_enable_n), .bank_addr(bank_addr), .addr(addr), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
      .chop_default(chop_default), .dll_enable(dll_enable), .bank_open(bank_open),
      .self_refresh(self_refresh), .power_down(power_down), .illegal_access(illegal_access)
   );
   always #2.5 clock = ~clock;
   task automatic report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   end
   endtask
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         $display("[FAIL] %0t run timed out", $time);
         report_and_stop;
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
   begin
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   end
   endtask
   task automatic wait_bank(input logic [7:0] exp);
      int k;
   begin
      k = 0;
      while (bank_open !== exp && k < 400)
      begin
         @(posedge clock);
         k++;
      end
      check(bank_open, exp, "open banks");
   end
   endtask
   task automatic t_burst;
   begin
      host.issue(`DDRBC_CMD_ACT, 3'h2, 15'h1234, 1'b1);
      wait_bank(8'h04);
      for (int i = 0; i < 8; i++)
         wdat[i] = 8'h3c + 8'(i * 9);
      host.issue(`DDRBC_CMD_WR, 3'h2, 15'h1000, 1'b1);
      host.write_beats(wdat, 8);
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_RD, 3'h2, 15'h1005, 1'b1);
      host.read_beats(8);
      for (int i = 0; i < 8; i++)
         check(host.rd_q[i], wdat[(i + 5) % 8], "wrapped burst");
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_RD, 3'h2, 15'h0006, 1'b1);
      host.read_beats(4);
      for (int i = 0; i < 4; i++)
         check(host.rd_q[i], wdat[4 + (i + 2) % 4], "chopped read");
      $display("t_burst done");
   end
   endtask
   task automatic t_chop;
      logic [7:0] nd [0:7];
   begin
      for (int j = 0; j < 8; j++)
         nd[j] = ~wdat[(1 + j) % 4];
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_WR, 3'h2, 15'h0001, 1'b1);
      host.write_beats(nd, 4);
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_RD, 3'h2, 15'h1000, 1'b1);
      host.read_beats(8);
      for (int i = 0; i < 8; i++)
         check(host.rd_q[i], i < 4 ? ~wdat[i] : wdat[i], "chopped write");
      @(posedge clock);
      #1 chop_default = 1'b1;
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_RD, 3'h2, 15'h1002, 1'b1);
      host.read_beats(4);
      for (int i = 0; i < 4; i++)
         check(host.rd_q[i], ~wdat[(i + 2) % 4], "programmed chop");
      repeat (2) @(posedge mem_clock);
      check({7'h00, dq_oe}, 8'h00, "programmed chop length");
      @(posedge clock);
      #1 chop_default = 1'b0;
      $display("t_chop done");
   end
   endtask
   task automatic t_banks;
   begin
      repeat (6) @(posedge mem_clock);
      host.issue(`DDRBC_CMD_ACT, 3'h3, 15'h0077, 1'b1);
      wait_bank(8'h0c);
      host.issue(`DDRBC_CMD_RD, 3'h5, 15'h1000, 1'b1);
      repeat (14) @(posedge mem_clock);
      check({7'h00, illegal_access}, 8'h01, "closed bank");
      host.issue(`DDRBC_CMD_RD, 3'h2, 15'h1400, 1'b1);
      host.read_beats(8);
      check(host.rd_q[0], ~wdat[0], "auto close read");
      check({7'h00, illegal_access}, 8'h00, "open bank");
      wait_bank(8'h08);
      $display("t_banks done");
   end
   endtask
   task automatic mode_step(input logic [2:0] code, input logic cke, input logic [7:0] exp);
   begin
      host.issue(code, 3'h0, 15'h0000, cke);
      repeat (3) @(posedge mem_clock);
      check({6'h00, self_refresh, power_down}, exp, "low power state");
   end
   endtask
   task automatic t_modes;
   begin
      @(posedge clock);
      #1 dll_enable = 1'b0;
      host.issue(`DDRBC_CMD_ACT, 3'h6, 15'h0001, 1'b1);
      repeat (4) @(posedge mem_clock);
      check(bank_open, 8'h08, "loop off");
      @(posedge clock);
      #1 dll_enable = 1'b1;
      host.issue(`DDRBC_CMD_PRE, 3'h0, 15'h0400, 1'b1);
      wait_bank(8'h00);
      repeat (host.refresh_scale(1'b1, 110))
         host.issue(`DDRBC_CMD_REF, 3'h0, 15'h0000, 1'b1);
      check({6'h00, self_refresh, power_down}, 8'h00, "refresh stays awake");
      mode_step(`DDRBC_CMD_REF, 1'b0, 8'h02);
      mode_step(`DDRBC_CMD_NOP, 1'b1, 8'h00);
      mode_step(`DDRBC_CMD_NOP, 1'b0, 8'h01);
      mode_step(`DDRBC_CMD_NOP, 1'b1, 8'h00);
      host.issue(`DDRBC_CMD_ACT, 3'h1, 15'h0002, 1'b1);
      wait_bank(8'h02);
      @(posedge clock);
      #1 reset_n = 1'b0;
      repeat (3) @(posedge clock);
      #1 reset_n = 1'b1;
      check(bank_open, 8'h00, "reset mid-run");
      $display("t_modes done");
   end
   endtask
   initial
   begin
      repeat (8) @(posedge clock);
      #1 reset_n = 1'b1;
      repeat (4) @(posedge clock);
      check({5'h00, dq_oe, dqs_oe, illegal_access}, 8'h00, "idle after reset");
      t_burst;
      t_chop;
      t_banks;
      t_modes;
      report_and_stop;
   end
endmodule // ddrbc_core_tb
